/* verilog/prst_cfg.svh */
// Constants for the transceiver reset, strap and reference-clock block.
// Assumes a 250 MHz system clock; the link side runs on the 50 MHz reference clock.
`ifndef PRST_CFG_SVH
`define PRST_CFG_SVH
`define PRST_CLK_PERIOD_PS   4000
`define PRST_TRISTATE_NS     50
`define PRST_TRISTATE_CYC    ((`PRST_TRISTATE_NS * 1000) / `PRST_CLK_PERIOD_PS)
`define PRST_DRIVE_CYC_25M   20
`define PRST_DRIVE_CYC_50M   40
`define PRST_CNT_W           6
`define PRST_MODE_OUT        1'h0
`endif

/* verilog/prst_pkg.sv */
// Types for the transceiver reset and strap sequencer.
// Assumes nothing beyond its users.
package prst_pkg;
   typedef enum logic [1:0] {
      PRST_HOLD,
      PRST_WAIT,
      PRST_RUN
   } prst_state_t;
endpackage : prst_pkg

/* verilog/prst_link_if.sv */
// Signals between the system-clock sequencer and the link-clock data port.
// Assumes both ends sit in the same device.
`timescale 1ns/1ps
interface prst_link_if;
   logic       driveEn;
   logic       linkRstn;
   modport seq  (output driveEn, output linkRstn);
   modport link (input driveEn, input linkRstn);
endinterface : prst_link_if

/* verilog/prst_link_port.sv */
// Reference-clock side: transmit sampling, receive launch and output enables.
// Assumes refClk is the 50 MHz reference; control arrives from the system clock.
`timescale 1ns/1ps
module prst_link_port (
   // Reference clock
   input  wire logic       refClk,
   // Control from sequencer
   prst_link_if.link       ctl,
   // MAC transmit side
   input  wire logic [1:0] txData,
   input  wire logic       txEnable,
   // Receive data from core
   input  wire logic [1:0] coreRxData,
   input  wire logic       coreRxErr,
   input  wire logic       coreCrsDv,
   // Pins
   output logic [1:0]      rxData,
   output logic            rxErr,
   output logic            crsDv,
   output logic            rxOe,
   output logic [1:0]      txDataSampled,
   output logic            txEnableSampled
);
   logic       enS1_q, enS2_q, enS1_d, enS2_d;
   logic [1:0] rxd_q, rxd_d, txd_q, txd_d;
   logic       rxe_q, rxe_d, crs_q, crs_d, txe_q, txe_d;

   always_comb begin
      enS1_d = ctl.driveEn;
      enS2_d = enS1_q;
      rxd_d  = coreRxData;
      rxe_d  = coreRxErr;
      crs_d  = coreCrsDv;
      txd_d  = txData;
      txe_d  = txEnable;
   end

   // Reset is applied asynchronously since the reference clock may be absent
   always_ff @(posedge refClk or negedge ctl.linkRstn) begin
      if (!ctl.linkRstn) begin
         enS1_q <= 1'h0;
         enS2_q <= 1'h0;
         rxd_q  <= 2'h0;
         rxe_q  <= 1'h0;
         crs_q  <= 1'h0;
         txd_q  <= 2'h0;
         txe_q  <= 1'h0;
      end else begin
         enS1_q <= enS1_d;
         enS2_q <= enS2_d;
         rxd_q  <= rxd_d;
         rxe_q  <= rxe_d;
         crs_q  <= crs_d;
         txd_q  <= txd_d;
         txe_q  <= txe_d;
      end
   end

   assign rxData          = rxd_q;
   assign rxErr           = rxe_q;
   assign crsDv           = crs_q;
   // Enable is dropped directly by reset so tri-state never waits on refClk
   assign rxOe            = enS2_q & ctl.driveEn;
   assign txDataSampled   = txd_q;
   assign txEnableSampled = txe_q;

   property p_rx_launch;
      @(posedge refClk) disable iff (!ctl.linkRstn)
         $past(ctl.linkRstn) |-> rxData == $past(coreRxData);
   endproperty
   a_rx_launch: assert property (p_rx_launch) else $error("receive dibit not launched on edge");

   property p_tx_sample;
      @(posedge refClk) disable iff (!ctl.linkRstn)
         $past(ctl.linkRstn) |-> (txDataSampled == $past(txData)) && (txEnableSampled == $past(txEnable));
   endproperty
   a_tx_sample: assert property (p_tx_sample) else $error("transmit not sampled on edge");

   property p_oe_gated;
      @(posedge refClk) disable iff (!ctl.linkRstn)
         rxOe |-> ctl.driveEn && $past(ctl.driveEn, 2);
   endproperty
   a_oe_gated: assert property (p_oe_gated) else $error("receive outputs driven while held");
endmodule : prst_link_port

/* verilog/prst_seq.sv */
// Top of the reset, strap-latch and reference-clock mode block.
// Assumes ext_reset_n and straps come from pins; refClk is the reference clock in use.
`timescale 1ns/1ps
`include "prst_cfg.svh"
module prst_seq #(
   parameter int CNT_W         = `PRST_CNT_W,
   parameter int DRIVE_CYC_25M = `PRST_DRIVE_CYC_25M,
   parameter int DRIVE_CYC_50M = `PRST_DRIVE_CYC_50M
) (
   // System clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // Reset pin and straps
   input  wire logic       extResetN,
   input  wire logic       refclkModeStrap,
   // Reference clocks
   input  wire logic       crystalIn,
   input  wire logic       refClockIn,
   input  wire logic       refClk,
   output logic            crystalOut,
   output logic            refClockOutEn,
   output logic            refClkFromCrystal,
   output logic            modeRefOut,
   // RMII
   input  wire logic [1:0] txData,
   input  wire logic       txEnable,
   input  wire logic [1:0] coreRxData,
   input  wire logic       coreRxErr,
   input  wire logic       coreCrsDv,
   output logic [1:0]      rxData,
   output logic            rxErr,
   output logic            crsDv,
   output logic            rxOe,
   output logic [1:0]      txDataSampled,
   output logic            txEnableSampled,
   // Management
   input  wire logic       mgmtClk,
   input  wire logic       mgmtDataIn,
   input  wire logic       mgmtReadActive,
   input  wire logic       mgmtReadBit,
   output logic            mgmtDataOut,
   output logic            mgmtDataOe,
   output logic            mgmtWriteBit,
   // Status
   output logic            outputsDriven
);
   prst_link_if lnk ();

   logic                  rstS1_q, rstS2_q, rstS1_d, rstS2_d;
   logic                  strapS1_q, strapS2_q, strapS1_d, strapS2_d;
   logic                  mode_q, mode_d;
   prst_pkg::prst_state_t state_q, state_d;
   logic [CNT_W-1:0]      cnt_q, cnt_d, target;
   logic                  drive_q, drive_d;
   logic                  waitReq_q, waitReq_d;
   logic                  doneS1_q, doneS2_q, doneS1_d, doneS2_d;
   logic                  wS1_q, wS2_q, wS1_d, wS2_d;
   logic                  done_q, done_d;
   logic                  mdo_q, mdw_q;

   // Counter must reach the longer delay before it saturates
   if (CNT_W < 1 || CNT_W > 16 || DRIVE_CYC_25M < 1 || DRIVE_CYC_50M < 1 ||
       DRIVE_CYC_25M > (1 << CNT_W) - 1 || DRIVE_CYC_50M > (1 << CNT_W) - 1) begin : g_bad_count
      $error("prst_seq: drive counts do not fit the counter width");
   end

   // Reset pin passes two flops; its assertion also acts directly on outputs
   always_comb begin
      rstS1_d   = extResetN;
      rstS2_d   = rstS1_q;
      strapS1_d = refclkModeStrap;
      strapS2_d = strapS1_q;
      // Straps track while reset is held, freeze at release
      mode_d    = (!rstS2_q) ? strapS2_q : mode_q;
      // Both modes count refClk cycles: DRIVE_CYC_25M of them in crystal mode, DRIVE_CYC_50M otherwise
      doneS1_d  = done_q;
      doneS2_d  = doneS1_q;
      target    = (mode_q == `PRST_MODE_OUT) ? CNT_W'(DRIVE_CYC_25M)
                                             : CNT_W'(DRIVE_CYC_50M);
      state_d   = state_q;
      drive_d   = 1'h0;
      unique case (state_q)
         prst_pkg::PRST_HOLD: begin
            if (rstS2_q) state_d = prst_pkg::PRST_WAIT;
         end
         prst_pkg::PRST_WAIT: begin
            // Only a synchronised flag crosses back; the count word never does
            if (doneS2_q) state_d = prst_pkg::PRST_RUN;
         end
         prst_pkg::PRST_RUN: drive_d = 1'h1;
      endcase
      if (!rstS2_q) begin
         state_d = prst_pkg::PRST_HOLD;
         drive_d = 1'h0;
      end
      // Registered before it crosses so a state change cannot glitch the far flop
      waitReq_d = (state_d == prst_pkg::PRST_WAIT);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rstS1_q   <= 1'h0;
         rstS2_q   <= 1'h0;
         strapS1_q <= 1'h1;
         strapS2_q <= 1'h1;
         mode_q    <= 1'h1;
         state_q   <= prst_pkg::PRST_HOLD;
         drive_q   <= 1'h0;
         waitReq_q <= 1'h0;
         doneS1_q  <= 1'h0;
         doneS2_q  <= 1'h0;
      end else begin
         rstS1_q   <= rstS1_d;
         rstS2_q   <= rstS2_d;
         strapS1_q <= strapS1_d;
         strapS2_q <= strapS2_d;
         mode_q    <= mode_d;
         state_q   <= state_d;
         drive_q   <= drive_d;
         waitReq_q <= waitReq_d;
         doneS1_q  <= doneS1_d;
         doneS2_q  <= doneS2_d;
      end
   end

   // Delay counter runs on the reference clock so cycle counts are exact.
   // Target comes from mode_q, which is frozen before the wait request can cross.
   always_comb begin
      wS1_d  = waitReq_q;
      wS2_d  = wS1_q;
      cnt_d  = cnt_q;
      if (wS2_q && cnt_q != '1) cnt_d = cnt_q + CNT_W'(1);
      done_d = wS2_q && (cnt_d >= target);
   end

   // Either reset clears the count, so a stale done flag never survives a restart
   always_ff @(posedge refClk or negedge lnk.linkRstn) begin
      if (!lnk.linkRstn) begin
         wS1_q  <= 1'h0;
         wS2_q  <= 1'h0;
         cnt_q  <= '0;
         done_q <= 1'h0;
      end else begin
         wS1_q  <= wS1_d;
         wS2_q  <= wS2_d;
         cnt_q  <= cnt_d;
         done_q <= done_d;
      end
   end

   // Pin reset drops enables combinationally, well inside 50 ns
   assign lnk.driveEn    = drive_q & extResetN & rstn;
   assign lnk.linkRstn   = extResetN & rstn;
   assign outputsDriven  = lnk.driveEn;
   assign modeRefOut     = ~mode_q;
   assign crystalOut     = ~crystalIn;
   assign refClkFromCrystal = (mode_q == `PRST_MODE_OUT);
   assign refClockOutEn  = lnk.driveEn & (mode_q == `PRST_MODE_OUT);

   prst_link_port u_link (
      .refClk          (refClk),
      .ctl             (lnk.link),
      .txData          (txData),
      .txEnable        (txEnable),
      .coreRxData      (coreRxData),
      .coreRxErr       (coreRxErr),
      .coreCrsDv       (coreCrsDv),
      .rxData          (rxData),
      .rxErr           (rxErr),
      .crsDv           (crsDv),
      .rxOe            (rxOe),
      .txDataSampled   (txDataSampled),
      .txEnableSampled (txEnableSampled)
   );

   // Management: read data launched on rising edge, write data sampled there
   always_ff @(posedge mgmtClk or negedge lnk.linkRstn) begin
      if (!lnk.linkRstn) begin
         mdo_q <= 1'h0;
         mdw_q <= 1'h0;
      end else begin
         mdo_q <= mgmtReadBit;
         mdw_q <= mgmtDataIn;
      end
   end
   assign mgmtDataOut  = mdo_q;
   assign mgmtDataOe   = mgmtReadActive & lnk.driveEn;
   assign mgmtWriteBit = mdw_q;

   property p_hold_no_drive;
      @(posedge clk) disable iff (!rstn)
         !rstS2_q |-> ##1 !drive_q;
   endproperty
   a_hold_no_drive: assert property (p_hold_no_drive) else $error("drive during reset");

   property p_pin_tristate;
      @(posedge clk) disable iff (!rstn)
         !extResetN |-> !outputsDriven && !rxOe && !mgmtDataOe && !refClockOutEn;
   endproperty
   a_pin_tristate: assert property (p_pin_tristate) else $error("outputs not released at reset");

   property p_strap_frozen;
      @(posedge clk) disable iff (!rstn)
         rstS2_q && $past(rstS2_q) |-> mode_q == $past(mode_q);
   endproperty
   a_strap_frozen: assert property (p_strap_frozen) else $error("strap changed in operation");

   property p_strap_capture;
      @(posedge clk) disable iff (!rstn)
         !rstS2_q |-> ##1 mode_q == $past(strapS2_q);
   endproperty
   a_strap_capture: assert property (p_strap_capture) else $error("strap not captured");

   property p_drive_after_count;
      @(posedge clk) disable iff (!rstn)
         $rose(drive_q) && extResetN |-> $past(doneS2_q, 2) && (cnt_q >= target);
   endproperty
   a_drive_after_count: assert property (p_drive_after_count) else $error("drive resumed early");

   property p_count_idle;
      @(posedge refClk) disable iff (!lnk.linkRstn)
         !$past(wS2_q) |-> cnt_q == $past(cnt_q);
   endproperty
   a_count_idle: assert property (p_count_idle) else $error("delay count moved outside wait");

   property p_refout_mode;
      @(posedge clk) disable iff (!rstn)
         refClockOutEn |-> !mode_q;
   endproperty
   a_refout_mode: assert property (p_refout_mode) else $error("clock out in wrong mode");
endmodule : prst_seq

/* test/prst_mac_model.sv */
// MAC and reset controller model facing the sequencer.
// Assumes refClk is the running reference clock; rnd comes from the bench.
`timescale 1ns/1ps
module prst_mac_model #(
   parameter int HOLD_CYC = 8
) (
   // Clock
   input  wire logic       refClk,
   // Bench control
   input  wire logic       rstReq,
   input  wire logic [2:0] rnd,
   // Pins
   output logic            extResetN,
   output logic [1:0]      txData,
   output logic            txEnable
);
   int holdCnt = HOLD_CYC;
   initial begin
      extResetN = 1'b0;
      txData = 2'h0;
      txEnable = 1'b0;
   end
   // Hold is scaled down; each request restarts the full minimum
   always @(posedge refClk) begin
      if (rstReq)
         holdCnt <= HOLD_CYC;
      else if (holdCnt != 0)
         holdCnt <= holdCnt - 1;
      extResetN <= !rstReq && holdCnt == 0;
   end
   // Launched after the edge, stable for the whole period
   always @(posedge refClk) begin
      {txEnable, txData} <= rnd;
   end
endmodule : prst_mac_model

/* test/tb.sv */
// Bench for the reset, strap and reference-clock sequencer.
// Assumes the MAC model; management clock made here.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin n_errors++; \
   $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module tb;
   logic        clk = 0, rstn = 0, refClk = 0, mgmtClk = 0, crystalIn = 0;
   logic        rstReq = 1, strap = 0, extResetN, txEnable, streamOn = 0;
   logic        coreRxErr = 0, coreCrsDv = 0, mgmtDataIn = 0, mgmtReadActive = 0, mgmtReadBit = 0;
   logic [1:0]  txData, coreRxData = 2'h0, rxData, txDataSampled, prevMg;
   logic        crystalOut, refClockOutEn, refClkFromCrystal, modeRefOut, rxErr, crsDv, rxOe;
   logic        txEnableSampled, mgmtDataOut, mgmtDataOe, mgmtWriteBit, outputsDriven;
   logic [3:0]  prevRx;
   logic [2:0]  prevTx;
   logic [31:0] seed = 32'h035A5B54;
   int          n_errors = 0, checks_done = 0;

   always #2 clk = ~clk;
   initial begin
      #7;
      forever #15 refClk = ~refClk;
   end
   always #200 mgmtClk = ~mgmtClk;
   always #20 crystalIn = ~crystalIn;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   prst_mac_model #(.HOLD_CYC(8)) prst_mac_model_inst (.refClk(refClk), .rstReq(rstReq),
      .rnd(seed[2:0]), .extResetN(extResetN), .txData(txData), .txEnable(txEnable));

   prst_seq prst_seq_inst (.clk(clk), .rstn(rstn), .extResetN(extResetN), .refclkModeStrap(strap),
      .crystalIn(crystalIn), .refClockIn(refClk), .refClk(refClk), .crystalOut(crystalOut),
      .refClockOutEn(refClockOutEn), .refClkFromCrystal(refClkFromCrystal), .modeRefOut(modeRefOut),
      .txData(txData), .txEnable(txEnable), .coreRxData(coreRxData), .coreRxErr(coreRxErr),
      .coreCrsDv(coreCrsDv), .rxData(rxData), .rxErr(rxErr), .crsDv(crsDv), .rxOe(rxOe),
      .txDataSampled(txDataSampled), .txEnableSampled(txEnableSampled), .mgmtClk(mgmtClk),
      .mgmtDataIn(mgmtDataIn), .mgmtReadActive(mgmtReadActive), .mgmtReadBit(mgmtReadBit),
      .mgmtDataOut(mgmtDataOut), .mgmtDataOe(mgmtDataOe), .mgmtWriteBit(mgmtWriteBit),
      .outputsDriven(outputsDriven));

   always @(posedge refClk) begin
      prevRx <= {coreRxErr, coreCrsDv, coreRxData};
      prevTx <= {txEnable, txData};
      seed <= lfsr(seed);
      {coreRxErr, coreCrsDv, coreRxData} <= seed[7:4];
   end
   always @(posedge mgmtClk) begin
      prevMg <= {mgmtReadBit, mgmtDataIn};
      {mgmtReadActive, mgmtReadBit, mgmtDataIn} <= seed[10:8];
   end
   always @(negedge refClk) if (streamOn) begin
      `CHK("rxPins", prevRx, {rxErr, crsDv, rxData})
      `CHK("txSampled", prevTx, {txEnableSampled, txDataSampled})
      `CHK("crystalOut", ~crystalIn, crystalOut)
   end
   always @(negedge mgmtClk) if (streamOn) begin
      `CHK("mgmtDataOut", prevMg[1], mgmtDataOut)
      `CHK("mgmtDataOe", mgmtReadActive, mgmtDataOe)
      `CHK("mgmtWriteBit", prevMg[0], mgmtWriteBit)
   end

   // Asserts reset mid-stream too, so the tri-state check sees live outputs
   task automatic doReset(input logic s, input int n);
      int k;
      streamOn = 0;
      @(posedge clk);
      rstReq <= 1'b1;
      strap <= s;
      if (extResetN)
         @(negedge extResetN);
      #50;
      `CHK("outputsDriven", 1'b0, outputsDriven)
      `CHK("rxOe", 1'b0, rxOe)
      `CHK("mgmtDataOe", 1'b0, mgmtDataOe)
      `CHK("refClockOutEn", 1'b0, refClockOutEn)
      @(posedge clk);
      rstReq <= 1'b0;
      @(posedge extResetN);
      k = 0;
      while (outputsDriven !== 1'b1 && k < 200) begin
         @(posedge refClk);
         k++;
      end
      `CHK("driveDelayInRange", 1'b1, k >= n && k <= n + 6)
      repeat (3) @(posedge refClk);
      #1;
      `CHK("refClkFromCrystal", !s, refClkFromCrystal)
      `CHK("modeRefOut", !s, modeRefOut)
      `CHK("refClockOutEn", !s, refClockOutEn)
      `CHK("rxOe", 1'b1, rxOe)
      @(posedge clk);
      strap <= !s;
      repeat (20) @(posedge clk);
      #1;
      `CHK("heldConfig", !s, refClkFromCrystal)
      streamOn = 1;
   endtask : doReset

   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : results

   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      doReset(1'b0, 20);
      $display("test crystal mode reset done");
      repeat (20) @(posedge mgmtClk);
      $display("test crystal mode stream done");
      doReset(1'b1, 40);
      $display("test reference-in reset done");
      repeat (20) @(posedge mgmtClk);
      $display("test reference-in stream done");
      results();
   end

   // Whole run is near 20 us; five times that means a hang
   initial begin
      #100000;
      n_errors++;
      results();
   end
endmodule : tb
